// ---- rtl/ovd_pkg.sv ----
package ovd_pkg;

	////////////////////////////////////////////////////////////////////////
	// clock and timing
	localparam int unsigned CLK_HZ          = 50_000_000;
	localparam int unsigned ID_DEBOUNCE_MS  = 10;
	// debounce length in cycles, rounded down as a longest settle time
	localparam int unsigned ID_DEBOUNCE_CYC = ID_DEBOUNCE_MS * (CLK_HZ / 1000);

	////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] EVENT_OFS  = 8'h08;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// control register fields
	localparam int CTRL_W         = 16;
	localparam int C_PUMP_OFF     = 0;
	localparam int C_EXT_OSC      = 1;
	localparam int C_VBUS_CHRG    = 2;
	localparam int C_VBUS_DISCHRG = 3;
	localparam int C_VBUS_DRV     = 4;
	localparam int C_DP_PU        = 5;
	localparam int C_DP_PD        = 6;
	localparam int C_DM_PU        = 7;
	localparam int C_DM_PD        = 8;
	localparam int C_UART_EN      = 9;
	localparam int C_UART_IO      = 10;
	localparam int C_AUDIO_EN     = 11;
	localparam int C_THR_SEL      = 12;
	localparam int C_PULSE_RISE   = 13;
	localparam int C_PULSE_FLAG_EN = 14;
	localparam int C_RCS_DIS      = 15;
	// pump off, current source disabled, line drive on, every other switch open
	localparam logic [15:0] CTRL_RST = 16'h8001;

	////////////////////////////////////////////////////////////////////////
	// status register fields (read only)
	localparam int S_VBUS_VALID = 0;
	localparam int S_SESS_VALID = 1;
	localparam int S_SESS_END   = 2;
	localparam int S_ID_GND     = 3;
	localparam int S_ID_FLOAT   = 4;
	localparam int S_PUMP_AT_TGT = 5;
	localparam int S_PUMP_OSC   = 6;

	////////////////////////////////////////////////////////////////////////
	// event register fields (sticky, write one to clear)
	localparam int         EV_W         = 2;
	localparam int         E_ID_CHANGED = 0;
	localparam int         E_CARKIT     = 1;
	localparam logic [1:0] EV_RST       = 2'h0;

	// id state after reset: floating, no device present
	localparam logic [1:0] ID_RST = 2'h1;

endpackage

// ---- rtl/ovd_id_debounce.sv ----
// holds {grounded, floating} until a new, non-conflicting value has been
// seen unchanged for STABLE_CYC cycles
module ovd_id_debounce #(
	parameter int unsigned STABLE_CYC = ovd_pkg::ID_DEBOUNCE_CYC
) (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       raw_gnd,
	input  wire logic       raw_float,
	output logic            id_gnd,
	output logic            id_float,
	output logic            id_changed
);
	localparam int CW = $clog2(STABLE_CYC + 1);

	initial
	begin
		if (STABLE_CYC < 2)
			$error("ovd_id_debounce: STABLE_CYC must be at least 2");
	end

	logic [1:0]    cand_r;
	logic [1:0]    stable_r;
	logic [CW-1:0] cnt_r;
	logic          chg_r;
	logic [1:0]    sample;

	assign sample = {raw_gnd, raw_float};

	// a both-high sample is plug bounce; it restarts the wait and never
	// qualifies, so the conflict cannot reach the status
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cand_r   <= ovd_pkg::ID_RST;
			stable_r <= ovd_pkg::ID_RST;
			cnt_r    <= '0;
			chg_r    <= 1'b0;
		end
		else
		begin
			chg_r <= 1'b0;
			if (sample != cand_r || sample == 2'h3)
			begin
				cand_r <= sample;
				cnt_r  <= '0;
			end
			else if (cnt_r != CW'(STABLE_CYC - 1))
				cnt_r <= cnt_r + 1'b1;
			else if (stable_r != cand_r)
			begin
				stable_r <= cand_r;
				chg_r    <= 1'b1;
			end
		end
	end

	assign id_gnd     = stable_r[1];
	assign id_float   = stable_r[0];
	assign id_changed = chg_r;

endmodule // ovd_id_debounce

// ---- rtl/ovd_carkit_detect.sv ----
// watches one D+ threshold and reports one-cycle pulses on a chosen edge
module ovd_carkit_detect (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic audio_en,
	input  wire logic flag_en,
	input  wire logic thr_sel,
	input  wire logic rise_edge,
	input  wire logic dp_above_hi,
	input  wire logic dp_above_lo,
	output logic      pulse_seen
);
	logic sel_cmp;
	logic prev_r;
	logic thr_q_r;
	logic edge_hit;

	// one comparator at a time: 1 picks the high level, 0 the low one
	assign sel_cmp  = thr_sel ? dp_above_hi : dp_above_lo;
	assign edge_hit = rise_edge ? (sel_cmp & ~prev_r)
	                            : (~sel_cmp & prev_r);

	// a threshold swap would look like an edge, so that cycle is skipped
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			prev_r  <= 1'b0;
			thr_q_r <= 1'b0;
		end
		else
		begin
			prev_r  <= sel_cmp;
			thr_q_r <= thr_sel;
		end
	end

	assign pulse_seen = audio_en & flag_en & edge_hit
	                    & (thr_sel == thr_q_r);

endmodule // ovd_carkit_detect

// ---- rtl/ovd_top.sv ----
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
module ovd_top #(
	parameter int unsigned DEBOUNCE_CYC = ovd_pkg::ID_DEBOUNCE_CYC
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// comparator results
	input  wire logic        vbus_valid_cmp,
	input  wire logic        sess_valid_cmp,
	input  wire logic        sess_end_cmp,
	input  wire logic        pump_at_target,
	input  wire logic        id_gnd_cmp,
	input  wire logic        id_float_cmp,
	input  wire logic        dp_above_hi_cmp,
	input  wire logic        dp_above_lo_cmp,
	// charge pump clocking
	input  wire logic        int_osc,
	input  wire logic        ext_osc,
	output logic             pump_enable,
	output logic             pump_osc,
	// analog switches
	output logic             vbus_charge_sw,
	output logic             vbus_discharge_sw,
	output logic             vbus_pump_sw,
	output logic             dp_pullup_sw,
	output logic             dp_pulldown_sw,
	output logic             dm_pullup_sw,
	output logic             dm_pulldown_sw,
	output logic             id_cs_enable,
	output logic             line_drive_en,
	// serial mux
	input  wire logic        line_rx,
	output logic             line_tx,
	input  wire logic        minus_line_tx_pin,
	input  wire logic        gpio_tx_pin,
	output logic             plus_line_rx_pin,
	output logic             plus_line_rx_pin_oe,
	output logic             gpio_rx_pin,
	output logic             gpio_rx_pin_oe
);

	initial
	begin
		if (DEBOUNCE_CYC < 2)
			$error("ovd_top: DEBOUNCE_CYC must be at least 2");
	end

	////////////////////////////////////////////////////////////////////////
	// state
	logic [ovd_pkg::CTRL_W-1:0] ctrl_r;
	logic [ovd_pkg::EV_W-1:0]   ev_r;
	logic                       aw_held_r;
	logic [7:0]                 aw_addr_r;
	logic                       w_held_r;
	logic [31:0]                w_data_r;
	logic [3:0]                 w_strb_r;
	logic                       bvalid_r;
	logic [1:0]                 bresp_r;
	logic                       rvalid_r;
	logic [1:0]                 rresp_r;
	logic [31:0]                rdata_r;
	logic                       pump_osc_r;
	logic                       line_tx_r;
	logic                       plus_rx_r;
	logic                       plus_rx_oe_r;
	logic                       gpio_rx_r;
	logic                       gpio_rx_oe_r;
	logic                       id_gnd_q_r;

	logic [31:0] wmask;
	logic        do_write;
	logic        wr_ctrl;
	logic        wr_event;
	logic        wr_hit;
	logic        id_gnd;
	logic        id_float;
	logic        id_changed;
	logic        carkit_hit;
	logic        id_gnd_fall;
	logic [31:0] status_word;
	logic [ovd_pkg::CTRL_W-1:0] ctrl_nxt;
	logic [ovd_pkg::EV_W-1:0]   ev_clr;

	////////////////////////////////////////////////////////////////////////
	// write channel: address and data are taken in either order, and
	// neither is accepted again until the response has been consumed
	assign s_axi_awready = ~aw_held_r & ~bvalid_r;
	assign s_axi_wready  = ~w_held_r & ~bvalid_r;
	assign do_write      = aw_held_r & w_held_r & ~bvalid_r;
	assign wr_ctrl  = do_write & (aw_addr_r == ovd_pkg::CTRL_OFS);
	assign wr_event = do_write & (aw_addr_r == ovd_pkg::EVENT_OFS);
	assign wr_hit   = wr_ctrl | wr_event
	                  | (aw_addr_r == ovd_pkg::STATUS_OFS);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_r <= 1'b1;
			aw_addr_r <= {s_axi_awaddr[7:2], 2'h0};
		end
		else if (do_write)
			aw_held_r <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end
		else if (do_write)
			w_held_r <= 1'b0;
	end

	// status is read only: a write there is accepted and dropped
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_r <= 1'b0;
			bresp_r  <= ovd_pkg::RESP_OKAY;
		end
		else if (do_write)
		begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_hit ? ovd_pkg::RESP_OKAY : ovd_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_r <= 1'b0;
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp  = bresp_r;

	// byte lanes to bit mask
	for (genvar b = 0; b < 4; b++)
	begin : g_lane
		assign wmask[8*b +: 8] = {8{w_strb_r[b]}};
	end

	////////////////////////////////////////////////////////////////////////
	// control register
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		if (wr_ctrl)
			ctrl_nxt = (ctrl_r & ~wmask[ovd_pkg::CTRL_W-1:0])
			         | (w_data_r[ovd_pkg::CTRL_W-1:0]
			            & wmask[ovd_pkg::CTRL_W-1:0]);
		// removal re-disables the source; it beats a write in the
		// same cycle so the source never stays on for a gone device
		if (id_gnd_fall)
			ctrl_nxt[ovd_pkg::C_RCS_DIS] = 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl_r <= ovd_pkg::CTRL_RST;
		else
			ctrl_r <= ctrl_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// id detection
	ovd_id_debounce #(
		.STABLE_CYC (DEBOUNCE_CYC)
	) u_id_debounce (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.raw_gnd    (id_gnd_cmp),
		.raw_float  (id_float_cmp),
		.id_gnd     (id_gnd),
		.id_float   (id_float),
		.id_changed (id_changed)
	);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			id_gnd_q_r <= 1'b0;
		else
			id_gnd_q_r <= id_gnd;
	end

	assign id_gnd_fall = id_gnd_q_r & ~id_gnd;

	////////////////////////////////////////////////////////////////////////
	// car-kit pulse watch
	ovd_carkit_detect u_carkit (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.audio_en    (ctrl_r[ovd_pkg::C_AUDIO_EN]),
		.flag_en     (ctrl_r[ovd_pkg::C_PULSE_FLAG_EN]),
		.thr_sel     (ctrl_r[ovd_pkg::C_THR_SEL]),
		.rise_edge   (ctrl_r[ovd_pkg::C_PULSE_RISE]),
		.dp_above_hi (dp_above_hi_cmp),
		.dp_above_lo (dp_above_lo_cmp),
		.pulse_seen  (carkit_hit)
	);

	////////////////////////////////////////////////////////////////////////
	// sticky events; a new event in the clearing cycle is kept
	assign ev_clr = wr_event
	                ? (w_data_r[ovd_pkg::EV_W-1:0]
	                   & wmask[ovd_pkg::EV_W-1:0])
	                : '0;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ev_r <= ovd_pkg::EV_RST;
		else
		begin
			ev_r <= ev_r & ~ev_clr;
			if (id_changed)
				ev_r[ovd_pkg::E_ID_CHANGED] <= 1'b1;
			if (carkit_hit)
				ev_r[ovd_pkg::E_CARKIT] <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read channel: one cycle from address to data
	always_comb
	begin
		status_word = 32'h0000_0000;
		status_word[ovd_pkg::S_VBUS_VALID]  = vbus_valid_cmp;
		status_word[ovd_pkg::S_SESS_VALID]  = sess_valid_cmp;
		status_word[ovd_pkg::S_SESS_END]    = sess_end_cmp;
		status_word[ovd_pkg::S_ID_GND]      = id_gnd;
		status_word[ovd_pkg::S_ID_FLOAT]    = id_float;
		status_word[ovd_pkg::S_PUMP_AT_TGT] = pump_at_target;
		status_word[ovd_pkg::S_PUMP_OSC]    = pump_osc_r;
	end

	assign s_axi_arready = ~rvalid_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_r <= 1'b0;
			rresp_r  <= ovd_pkg::RESP_OKAY;
			rdata_r  <= 32'h0000_0000;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_r <= 1'b1;
			rresp_r  <= ovd_pkg::RESP_OKAY;
			case ({s_axi_araddr[7:2], 2'h0})
				ovd_pkg::CTRL_OFS:
					rdata_r <= {16'h0000, ctrl_r};
				ovd_pkg::STATUS_OFS:
					rdata_r <= status_word;
				ovd_pkg::EVENT_OFS:
					rdata_r <= {30'h0000_0000, ev_r};
				default:
				begin
					rdata_r <= 32'h0000_0000;
					rresp_r <= ovd_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
			rvalid_r <= 1'b0;
	end

	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp  = rresp_r;
	assign s_axi_rdata  = rdata_r;

	////////////////////////////////////////////////////////////////////////
	// charge pump gating; the oscillator inputs are sampled, so they must
	// be well below half the system clock
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pump_osc_r <= 1'b0;
		else
			pump_osc_r <= ~ctrl_r[ovd_pkg::C_PUMP_OFF]
			              & ~pump_at_target
			              & (ctrl_r[ovd_pkg::C_EXT_OSC]
			                 ? ext_osc : int_osc);
	end

	assign pump_osc    = pump_osc_r;
	assign pump_enable = ~ctrl_r[ovd_pkg::C_PUMP_OFF];

	////////////////////////////////////////////////////////////////////////
	// switches straight from their own control bits
	assign vbus_charge_sw    = ctrl_r[ovd_pkg::C_VBUS_CHRG];
	assign vbus_discharge_sw = ctrl_r[ovd_pkg::C_VBUS_DISCHRG];
	assign vbus_pump_sw      = ctrl_r[ovd_pkg::C_VBUS_DRV];
	assign dp_pullup_sw      = ctrl_r[ovd_pkg::C_DP_PU];
	assign dp_pulldown_sw    = ctrl_r[ovd_pkg::C_DP_PD];
	assign dm_pullup_sw      = ctrl_r[ovd_pkg::C_DM_PU];
	assign dm_pulldown_sw    = ctrl_r[ovd_pkg::C_DM_PD];
	assign id_cs_enable      = ~ctrl_r[ovd_pkg::C_RCS_DIS];
	// serial mode wins over audio when both bits are set
	assign line_drive_en     = ctrl_r[ovd_pkg::C_UART_EN]
	                           | ~ctrl_r[ovd_pkg::C_AUDIO_EN];

	////////////////////////////////////////////////////////////////////////
	// serial mux; with serial mode off both receive pins are released and line_tx is held low
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			line_tx_r    <= 1'b0;
			plus_rx_r    <= 1'b0;
			plus_rx_oe_r <= 1'b0;
			gpio_rx_r    <= 1'b0;
			gpio_rx_oe_r <= 1'b0;
		end
		else if (ctrl_r[ovd_pkg::C_UART_EN])
		begin
			line_tx_r    <= ctrl_r[ovd_pkg::C_UART_IO]
			                ? gpio_tx_pin : minus_line_tx_pin;
			plus_rx_r    <= line_rx;
			plus_rx_oe_r <= ~ctrl_r[ovd_pkg::C_UART_IO];
			gpio_rx_r    <= line_rx;
			gpio_rx_oe_r <= ctrl_r[ovd_pkg::C_UART_IO];
		end
		else
		begin
			line_tx_r    <= 1'b0;
			plus_rx_oe_r <= 1'b0;
			gpio_rx_oe_r <= 1'b0;
		end
	end

	assign line_tx             = line_tx_r;
	assign plus_line_rx_pin    = plus_rx_r;
	assign plus_line_rx_pin_oe = plus_rx_oe_r;
	assign gpio_rx_pin         = gpio_rx_r;
	assign gpio_rx_pin_oe      = gpio_rx_oe_r;

endmodule // ovd_top

// ---- dv/ovd_top_sva.sv ----
// watches the register bus handshakes, the pump gate and the serial mux
module ovd_top_sva (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        s_axi_awvalid,
	input  wire logic        s_axi_awready,
	input  wire logic        s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        pump_at_target,
	input  wire logic        int_osc,
	input  wire logic        ext_osc,
	input  wire logic        pump_enable,
	input  wire logic        pump_osc,
	input  wire logic        line_drive_en,
	input  wire logic        line_tx,
	input  wire logic        minus_line_tx_pin,
	input  wire logic        gpio_tx_pin,
	input  wire logic        line_rx,
	input  wire logic        plus_line_rx_pin,
	input  wire logic        gpio_rx_pin,
	input  wire logic        plus_line_rx_pin_oe,
	input  wire logic        gpio_rx_pin_oe
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	////////////////////////////////////////////////////////////////////////
	// transfer steps of the register bus
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence

	a_wr_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
		else $error("read response late");
	// a stalled answer must not change under the master
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read response dropped");
	a_busy_refuse: assert property ((s_axi_bvalid |-> !s_axi_awready
		&& !s_axi_wready) and (s_axi_rvalid |-> !s_axi_arready))
		else $error("request taken while busy");

	////////////////////////////////////////////////////////////////////////
	// pump oscillator gate, one cycle behind its causes
	a_pump_gated: assert property ($past(pump_at_target)
		|| !$past(pump_enable) |-> !pump_osc)
		else $error("pump runs at target or off");
	a_pump_runs: assert property ($past(pump_enable)
		&& !$past(pump_at_target) && $past(int_osc) && $past(ext_osc)
		|-> pump_osc)
		else $error("pump idle below target");

	////////////////////////////////////////////////////////////////////////
	// serial mux routing and line release
	a_tx_direct: assert property (plus_line_rx_pin_oe
		|-> line_tx == $past(minus_line_tx_pin))
		else $error("direct transmit wrong");
	a_tx_alt: assert property (gpio_rx_pin_oe
		|-> line_tx == $past(gpio_tx_pin))
		else $error("alternate transmit wrong");
	a_tx_off: assert property (!(plus_line_rx_pin_oe
		|| gpio_rx_pin_oe) |-> !line_tx)
		else $error("transmit active with serial off");
	a_rx_follow: assert property ((plus_line_rx_pin_oe
		|| gpio_rx_pin_oe) |-> plus_line_rx_pin == $past(line_rx)
		&& gpio_rx_pin == $past(line_rx))
		else $error("receive data not passed on");
	a_route_one: assert property (!(plus_line_rx_pin_oe
		&& gpio_rx_pin_oe))
		else $error("both receive pins driven");
	a_audio_quiet: assert property ((plus_line_rx_pin_oe
		|| gpio_rx_pin_oe) |-> $past(line_drive_en))
		else $error("serial drive while lines released");
endmodule // ovd_top_sva

// ---- dv/ovd_cable_model.sv ----
// far end of the cable: id pin load and d+ level as seen by comparators
module ovd_cable_model (
	input  wire logic       aclk,
	input  wire logic [1:0] id_cls,
	input  wire logic [1:0] dp_lvl,
	output logic            id_gnd_cmp,
	output logic            id_float_cmp,
	output logic            dp_above_hi_cmp,
	output logic            dp_above_lo_cmp
);
	logic [1:0] last_r = 2'h0;
	logic [2:0] bnc_r  = 3'h0;

	////////////////////////////////////////////////////////////////////////
	// any plug change rattles both comparators for five cycles
	always_ff @(posedge aclk)
	begin
		last_r <= id_cls;
		if (id_cls != last_r)
			bnc_r <= 3'h5;
		else if (bnc_r != 3'h0)
			bnc_r <= bnc_r - 3'h1;
	end

	// class 0 floating, 1 grounded, 2 through a resistor
	assign id_gnd_cmp   = (bnc_r != 3'h0) ? bnc_r[0] : (id_cls == 2'h1);
	assign id_float_cmp = (bnc_r != 3'h0) ? bnc_r[0] : (id_cls == 2'h0);
	// level 0 below both, 1 between, 2 above the high threshold
	assign dp_above_hi_cmp = (dp_lvl == 2'h2);
	assign dp_above_lo_cmp = (dp_lvl != 2'h0);
endmodule // ovd_cable_model

// ---- dv/ovd_top_tb_top.sv ----
module ovd_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// short debounce keeps the id scenarios quick
	localparam int unsigned DB = 8;
	localparam int WAIT_ID = DB + 12;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp, id_cls = 2'h0, dp_lvl = 2'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, id_gnd_cmp, id_float_cmp;
	logic vbus_valid_cmp = 1'b0, sess_valid_cmp = 1'b0, sess_end_cmp = 1'b0;
	logic pump_at_target = 1'b0, int_osc = 1'b0, ext_osc = 1'b0;
	logic line_rx = 1'b0, minus_line_tx_pin = 1'b1, gpio_tx_pin = 1'b0;
	logic dp_above_hi_cmp, dp_above_lo_cmp, pump_enable, pump_osc;
	logic vbus_charge_sw, vbus_discharge_sw, vbus_pump_sw, dp_pullup_sw;
	logic dp_pulldown_sw, dm_pullup_sw, dm_pulldown_sw, id_cs_enable;
	logic line_drive_en, line_tx, plus_line_rx_pin, plus_line_rx_pin_oe;
	logic gpio_rx_pin, gpio_rx_pin_oe;
	int n_mismatch = 0, check_count = 0;
	// carkit cases: control, d+ level before and after, flag expected
	logic [15:0] ck_ctl [8] = '{16'hf801, 16'hf801, 16'he801, 16'he801,
		16'hd801, 16'hd801, 16'hb801, 16'hf001};
	logic [15:0] ck_from = 16'h5681;
	logic [15:0] ck_to   = 16'ha966;
	logic [7:0]  ck_exp  = 8'h15;

	ovd_top #(.DEBOUNCE_CYC(DB)) uut (.*);
	ovd_cable_model u_cable (.aclk, .id_cls, .dp_lvl, .id_gnd_cmp,
		.id_float_cmp, .dp_above_hi_cmp, .dp_above_lo_cmp);

	////////////////////////////////////////////////////////////////////////
	// clock, receive activity and the hang guard
	initial forever #10 aclk = ~aclk;
	always @(posedge aclk) line_rx <= ~line_rx;
	// the whole sequence needs well under ten thousand cycles
	initial
	begin
		#200_000;
		n_mismatch++;
		close_out();
	end

	////////////////////////////////////////////////////////////////////////
	// comparison and bus tasks
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	// answers are taken a cycle late so the slave must hold them
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw_p, w_p;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		{aw_p, w_p} = 2'h3;
		while (aw_p || w_p)
		begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) aw_p = 1'b0;
			if (s_axi_wready === 1'b1) w_p = 1'b0;
			s_axi_awvalid <= aw_p;
			s_axi_wvalid <= w_p;
		end
		repeat (2) @(posedge aclk);
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rdr(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		@(posedge aclk);
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic wo(input logic [7:0] a, input logic [31:0] d);
		wr(a, d, rsp);
		chk(rsp, ovd_pkg::RESP_OKAY);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		rdr(a, rd, rsp);
		chk(rsp, ovd_pkg::RESP_OKAY);
		chk(rd & m, e);
	endtask

	task automatic pmp(input logic at, input logic io, input logic eo,
		input logic ex);
		@(posedge aclk);
		pump_at_target <= at;
		int_osc <= io;
		ext_osc <= eo;
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		chk(pump_osc, ex);
	endtask

	task automatic ser(input logic [31:0] c, input logic m, input logic g,
		input logic [31:0] ex);
		minus_line_tx_pin <= m;
		gpio_tx_pin <= g;
		wo(ovd_pkg::CTRL_OFS, c);
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		chk({line_tx, plus_line_rx_pin_oe, gpio_rx_pin_oe}, ex);
	endtask

	task automatic idw(input logic [1:0] c);
		@(posedge aclk);
		id_cls <= c;
		repeat (WAIT_ID) @(posedge aclk);
	endtask

	task automatic close_out();
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rc(ovd_pkg::CTRL_OFS, 32'hffff, 32'h8001);
		rc(ovd_pkg::EVENT_OFS, 32'h3, 32'h0);
		chk({pump_enable, id_cs_enable, line_drive_en}, 32'h1);
		// unmapped places refuse, status ignores writes
		rdr(8'h0c, rd, rsp);
		chk(rsp, ovd_pkg::RESP_SLVERR);
		chk(rd, 32'h0);
		wr(8'h10, 32'h0, rsp);
		chk(rsp, ovd_pkg::RESP_SLVERR);
		wo(ovd_pkg::STATUS_OFS, 32'hff);
		rc(ovd_pkg::CTRL_OFS, 32'hffff, 32'h8001);
		for (int k = 0; k < 8; k++)
		begin
			{sess_end_cmp, sess_valid_cmp, vbus_valid_cmp} <= k[2:0];
			rc(ovd_pkg::STATUS_OFS, 32'h7, k);
		end
		// one switch at a time, then charge and discharge together
		for (int i = 2; i < 9; i++)
		begin
			wo(ovd_pkg::CTRL_OFS, 32'h8001 | (32'h1 << i));
			@(negedge aclk);
			chk({dm_pulldown_sw, dm_pullup_sw, dp_pulldown_sw, dp_pullup_sw,
				vbus_pump_sw, vbus_discharge_sw, vbus_charge_sw},
				32'h1 << (i - 2));
		end
		wo(ovd_pkg::CTRL_OFS, 32'h800d);
		chk({vbus_pump_sw, vbus_discharge_sw, vbus_charge_sw}, 32'h3);
		// pump gating and clock source choice
		wo(ovd_pkg::CTRL_OFS, 32'h8000);
		pmp(1'b0, 1'b1, 1'b0, 1'b1);
		pmp(1'b1, 1'b1, 1'b1, 1'b0);
		pmp(1'b0, 1'b0, 1'b1, 1'b0);
		pmp(1'b0, 1'b1, 1'b1, 1'b1);
		wo(ovd_pkg::CTRL_OFS, 32'h8002);
		pmp(1'b0, 1'b0, 1'b1, 1'b1);
		pmp(1'b0, 1'b1, 1'b0, 1'b0);
		wo(ovd_pkg::CTRL_OFS, 32'h8003);
		pmp(1'b0, 1'b1, 1'b1, 1'b0);
		chk(pump_enable, 32'h0);
		// serial routes, then serial off with the route bit left set
		ser(32'h8601, 1'b0, 1'b1, 32'h5);
		ser(32'h8201, 1'b1, 1'b0, 32'h6);
		ser(32'h8401, 1'b1, 1'b1, 32'h0);
		wo(ovd_pkg::CTRL_OFS, 32'h8801);
		@(negedge aclk);
		chk(line_drive_en, 32'h0);
		// carkit detector over threshold, polarity and enables
		for (int i = 0; i < 8; i++)
		begin
			dp_lvl <= ck_from[2 * i +: 2];
			wo(ovd_pkg::CTRL_OFS, {16'h0, ck_ctl[i]});
			wo(ovd_pkg::EVENT_OFS, 32'h3);
			dp_lvl <= ck_to[2 * i +: 2];
			repeat (3) @(posedge aclk);
			rc(ovd_pkg::EVENT_OFS, 32'h2, {ck_exp[i], 1'b0});
		end
		// id insertion, current source, removal, glitch, resistive load
		wo(ovd_pkg::CTRL_OFS, 32'h8001);
		idw(2'h1);
		rc(ovd_pkg::STATUS_OFS, 32'h18, 32'h08);
		rc(ovd_pkg::EVENT_OFS, 32'h1, 32'h1);
		wo(ovd_pkg::EVENT_OFS, 32'h1);
		rc(ovd_pkg::EVENT_OFS, 32'h1, 32'h0);
		wo(ovd_pkg::CTRL_OFS, 32'h0001);
		@(negedge aclk);
		chk(id_cs_enable, 32'h1);
		idw(2'h0);
		chk(id_cs_enable, 32'h0);
		rc(ovd_pkg::CTRL_OFS, 32'hffff, 32'h8001);
		wo(ovd_pkg::EVENT_OFS, 32'h1);
		id_cls <= 2'h1;
		idw(2'h0);
		rc(ovd_pkg::EVENT_OFS, 32'h1, 32'h0);
		rc(ovd_pkg::STATUS_OFS, 32'h18, 32'h10);
		idw(2'h2);
		rc(ovd_pkg::STATUS_OFS, 32'h18, 32'h0);
		rc(ovd_pkg::EVENT_OFS, 32'h1, 32'h1);
		close_out();
	end
endmodule // ovd_top_tb_top

bind ovd_top ovd_top_sva u_sva (.*);
